// file: hw/iosad_defs.svh
`ifndef IOSAD_DEFS_SVH
`define IOSAD_DEFS_SVH
// address space limits
`define IOSAD_IO_SHORT_LAST 8'h3F
`define IOSAD_IO_BIT_LAST   8'h1F
`define IOSAD_IO_DATA_OFS   8'h20
`define IOSAD_IO_DATA_LAST  8'h5F
`define IOSAD_EXT_FIRST     8'h60
`define IOSAD_EXT_LAST      8'hFF
// local register placement, in i/o numbering
`define IOSAD_SPD_IO        8'h0E
`define IOSAD_SPS_IO        8'h0D
// status field positions
`define IOSAD_DONE_BIT      7
`define IOSAD_COLL_BIT      6
`define IOSAD_DRS_BIT       0
// reset values
`define IOSAD_SPD_RST       8'h00
`define IOSAD_SPS_RST       8'h00
`endif

// file: hw/iosad_pkg.sv
package iosad_pkg;
  // instruction kinds seen by the decoder
  typedef enum logic [3:0] {
    OP_IN            = 4'h0,
    OP_OUT           = 4'h1,
    OP_SET_IO_BIT    = 4'h2,
    OP_CLEAR_IO_BIT  = 4'h3,
    OP_SKIP_BIT_SET  = 4'h4,
    OP_SKIP_BIT_CLR  = 4'h5,
    OP_DATA_LOAD     = 4'h6,
    OP_DATA_STORE    = 4'h7
  } iosad_kind_e;
  // request from the core
  typedef struct packed {
    logic        valid;
    iosad_kind_e kind;
    logic [7:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } iosad_req_s;
  // answer to the core
  typedef struct packed {
    logic       done;
    logic       err;
    logic       skip;
    logic [7:0] rdata;
  } iosad_rsp_s;
  // access toward the peripheral registers, data-space address
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iosad_per_s;
  // decoder result
  typedef struct packed {
    logic       legal;
    logic [7:0] daddr;
  } iosad_dec_s;
endpackage

// file: hw/iosad_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "iosad_defs.svh"
module iosad_decode (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire iosad_pkg::iosad_req_s req,
  output var  logic              req_ready,
  output var  iosad_pkg::iosad_rsp_s rsp,
  output var  iosad_pkg::iosad_per_s per,
  input  wire logic [7:0]        per_rdata,
  input  wire logic              xfer_done_evt,
  input  wire logic              collision_evt,
  output var  logic [7:0]        serial_port_data_out,
  output var  logic              double_rate_select
);
  import iosad_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // map an instruction's address to data space and judge reach
  function automatic iosad_dec_s decode(input iosad_kind_e k, input logic [7:0] a);
    iosad_dec_s d;
    d.legal = 1'b0;
    d.daddr = 8'h00;
    case (k)
      OP_IN, OP_OUT: begin
        d.legal = (a <= `IOSAD_IO_SHORT_LAST);
        d.daddr = a + `IOSAD_IO_DATA_OFS;
      end
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR: begin
        d.legal = (a <= `IOSAD_IO_BIT_LAST);
        d.daddr = a + `IOSAD_IO_DATA_OFS;
      end
      default: begin
        // load/store reach both i/o windows, not the register file below
        d.legal = (a >= `IOSAD_IO_DATA_OFS);
        d.daddr = a;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_READ  = 2'b01,
    PH_WRITE = 2'b10
  } iosad_ph_e;

  iosad_ph_e   state, next_state;         // sequencer
  iosad_kind_e kind, next_kind;           // held instruction kind
  logic [7:0]  daddr, next_daddr;         // held data-space address
  logic [2:0]  bsel, next_bsel;           // held bit index
  logic [7:0]  wbuf, next_wbuf;           // value to write
  logic [7:0]  spd, next_spd;             // serial_port_data
  logic [7:0]  sps, next_sps;             // serial_port_status
  iosad_rsp_s  next_rsp;                  // answer
  iosad_per_s  next_per;                  // peripheral access
  logic        next_ready;                // ready to take
  iosad_dec_s  dec;                       // decode of incoming request
  logic [7:0]  rd_val;                    // current value at daddr
  logic        is_spd, is_sps;            // local register hits
  logic        do_write;                  // write lands this cycle

  assign dec    = decode(req.kind, req.addr);
  assign is_spd = (daddr == `IOSAD_SPD_IO + `IOSAD_IO_DATA_OFS);
  assign is_sps = (daddr == `IOSAD_SPS_IO + `IOSAD_IO_DATA_OFS);
  // local registers answer locally, others come from the peripheral side
  assign rd_val = is_spd ? spd : (is_sps ? sps : per_rdata);
  assign do_write = (state == PH_WRITE);

  // ----------------------------------------
  // sequencer and bus side next values
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_daddr = daddr;
    next_bsel  = bsel;
    next_wbuf  = wbuf;
    next_rsp   = '0;
    next_per   = '0;
    case (state)
      PH_IDLE: begin
        if (req.valid) begin
          next_kind  = req.kind;
          next_daddr = dec.daddr;
          next_bsel  = req.bit_sel;
          next_wbuf  = req.wdata;
          if (!dec.legal) begin
            // out-of-reach access: refused at once
            next_rsp.done = 1'b1;
            next_rsp.err  = 1'b1;
          end else if (req.kind == OP_OUT || req.kind == OP_DATA_STORE) begin
            next_state    = PH_WRITE;
            next_per.valid = 1'b1;
            next_per.write = 1'b1;
            next_per.addr  = dec.daddr;
            next_per.wdata = req.wdata;
          end else begin
            next_state     = PH_READ;
            next_per.valid = 1'b1;
            next_per.addr  = dec.daddr;
          end
        end
      end
      PH_READ: begin
        case (kind)
          OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
            // whole register read back, one bit changed, all written
            next_wbuf = rd_val;
            next_wbuf[bsel] = (kind == OP_SET_IO_BIT);
            next_state     = PH_WRITE;
            next_per.valid = 1'b1;
            next_per.write = 1'b1;
            next_per.addr  = daddr;
            next_per.wdata = next_wbuf;
          end
          OP_SKIP_BIT_SET: begin
            next_rsp.done  = 1'b1;
            next_rsp.skip  = rd_val[bsel];
            next_rsp.rdata = rd_val;
            next_state     = PH_IDLE;
          end
          OP_SKIP_BIT_CLR: begin
            next_rsp.done  = 1'b1;
            next_rsp.skip  = !rd_val[bsel];
            next_rsp.rdata = rd_val;
            next_state     = PH_IDLE;
          end
          default: begin
            // plain load or in
            next_rsp.done  = 1'b1;
            next_rsp.rdata = rd_val;
            next_state     = PH_IDLE;
          end
        endcase
      end
      PH_WRITE: begin
        next_rsp.done = 1'b1;
        next_state    = PH_IDLE;
      end
      default: next_state = PH_IDLE;
    endcase
    next_ready = (next_state == PH_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= PH_IDLE;
      kind      <= OP_IN;
      daddr     <= 8'h00;
      bsel      <= 3'h0;
      wbuf      <= 8'h00;
      rsp       <= '0;
      per       <= '0;
      req_ready <= 1'b1;
    end else if (ce) begin
      state     <= next_state;
      kind      <= next_kind;
      daddr     <= next_daddr;
      bsel      <= next_bsel;
      wbuf      <= next_wbuf;
      rsp       <= next_rsp;
      per       <= next_per;
      req_ready <= next_ready;
    end
  end

  // ----------------------------------------
  // local serial port registers
  // ----------------------------------------
  // status flags clear on a one, hold on a zero; a new event wins
  always_comb begin
    next_spd = spd;
    next_sps = sps;
    if (do_write && is_spd) begin
      next_spd = wbuf;
    end
    if (do_write && is_sps) begin
      next_sps[`IOSAD_DRS_BIT]  = wbuf[`IOSAD_DRS_BIT];
      // a written zero takes no branch, so the flag holds
      if (wbuf[`IOSAD_DONE_BIT]) begin
        next_sps[`IOSAD_DONE_BIT] = 1'b0;
      end
      if (wbuf[`IOSAD_COLL_BIT]) begin
        next_sps[`IOSAD_COLL_BIT] = 1'b0;
      end
    end
    if (xfer_done_evt) begin
      next_sps[`IOSAD_DONE_BIT] = 1'b1;
    end
    if (collision_evt) begin
      next_sps[`IOSAD_COLL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spd                  <= `IOSAD_SPD_RST;
      sps                  <= `IOSAD_SPS_RST;
      serial_port_data_out <= `IOSAD_SPD_RST;
      double_rate_select   <= 1'b0;
    end else if (ce) begin
      spd                  <= next_spd;
      sps                  <= next_sps;
      serial_port_data_out <= next_spd;
      double_rate_select   <= next_sps[`IOSAD_DRS_BIT];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // skip-if-set answer carries the tested bit of the value read
  a_skip_set_value: assert property (
    ce && state == PH_READ && kind == OP_SKIP_BIT_SET ##1 ce
    |-> rsp.done && rsp.skip == $past(rd_val[bsel]) && rsp.rdata == $past(rd_val))
    else $error("skip-if-set answer does not match tested bit");
  // bit set and bit clear above the low 32 are refused with no access
  a_bit_range: assert property (
    ce && state == PH_IDLE && req.valid
    && (req.kind == OP_SET_IO_BIT || req.kind == OP_CLEAR_IO_BIT)
    && req.addr > `IOSAD_IO_BIT_LAST |=> rsp.done && rsp.err && !per.valid)
    else $error("bit operation above i/o 0x1F not refused");
  // a written one drops the done flag unless a new event comes
  a_w1c_clear: assert property (
    ce && do_write && is_sps && wbuf[`IOSAD_DONE_BIT] && !xfer_done_evt
    |=> !sps[`IOSAD_DONE_BIT])
    else $error("done flag not cleared by written one");
  // bit clear writes back the whole value read, one bit low
  a_rmw_write: assert property (
    ce && state == PH_READ && kind == OP_CLEAR_IO_BIT
    |=> per.valid && per.write && per.wdata == ($past(rd_val) & ~(8'h01 << $past(bsel))))
    else $error("bit clear did not write back the whole register");
  // in beyond the short window is refused
  a_short_range: assert property (
    ce && state == PH_IDLE && req.valid && req.kind == OP_IN
    && req.addr > `IOSAD_IO_SHORT_LAST |=> rsp.done && rsp.err)
    else $error("in beyond i/o 0x3F not refused");
  // out lands at its i/o number plus the data-space offset
  a_data_offset: assert property (
    ce && state == PH_IDLE && req.valid && req.kind == OP_OUT
    && req.addr <= `IOSAD_IO_SHORT_LAST |=> per.valid && per.write
    && per.addr == $past(req.addr) + `IOSAD_IO_DATA_OFS)
    else $error("i/o address not offset by 0x20");
  // load reaches the extended region and answers a cycle later
  a_ext_reach: assert property (
    ce && state == PH_IDLE && req.valid && req.kind == OP_DATA_LOAD
    && req.addr >= `IOSAD_EXT_FIRST |=> per.valid && !rsp.err ##1 rsp.done)
    else $error("extended region not reached by load");
  // a written zero leaves a raised collision flag up
  a_zero_holds: assert property (
    ce && do_write && is_sps && !wbuf[`IOSAD_COLL_BIT] && sps[`IOSAD_COLL_BIT]
    |=> sps[`IOSAD_COLL_BIT])
    else $error("collision flag changed by written zero");

  c_rmw_status: cover property (ce && state == PH_READ && kind == OP_SET_IO_BIT && is_sps);
  c_refused: cover property (rsp.done && rsp.err);
  c_skip_taken: cover property (rsp.done && rsp.skip);
  c_ext_store: cover property (per.valid && per.write && per.addr >= 8'h60);
endmodule
`default_nettype wire

// file: tb/iosad_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// peripheral register stand-in, far side
// ----------------------------------------
module iosad_periph_model (
  input  wire logic                  clk,
  input  wire iosad_pkg::iosad_per_s per,
  output var  logic [7:0]            per_rdata
);
  import iosad_pkg::*;
  logic [7:0] mem [256];     // register image, data-space numbering
  logic [7:0] junk = 8'h3C;  // filler that moves every cycle
  // known power-up image, so read-modify-write never meets unknown bits
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h96;
    end
  end
  // writes land at the edge, filler keeps changing
  always @(posedge clk) begin
    junk <= junk + 8'h5B;
    if (per.valid && per.write) begin
      mem[per.addr] <= per.wdata;
    end
  end
  // read data is valid only while a read is shown
  always_comb begin
    per_rdata = (per.valid && !per.write) ? mem[per.addr] : junk;
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import iosad_pkg::*;
  logic       clk = 1'b0;    // core clock
  logic       rst_b;         // reset, active low
  logic       ce;            // clock enable
  logic       xfer_done_evt; // done event pulse
  logic       collision_evt; // collision event pulse
  iosad_req_s req;           // request to the block
  logic       req_ready;     // block idle
  iosad_rsp_s rsp;           // answer
  iosad_rsp_s got;           // answer captured by op
  iosad_per_s per;           // peripheral access
  logic [7:0] per_rdata;     // peripheral read data
  logic [7:0] spd_out;       // data register copy
  logic       drs;           // rate select copy
  logic [7:0] a;             // address under test
  logic [7:0] d;             // data under test
  logic [2:0] b;             // bit under test
  int         fail_count;
  int         samples_checked;
  int         cycles;
  // edge addresses, one per kind in encoding order
  logic [7:0] bnd [8] = '{8'h40, 8'h3F, 8'h20, 8'h1F, 8'h1F, 8'h20, 8'h1F, 8'h60};

  always #2.5 clk = ~clk;

  iosad_decode i_iosad_decode (.clk(clk), .rst_b(rst_b), .ce(ce), .req(req),
    .req_ready(req_ready), .rsp(rsp), .per(per), .per_rdata(per_rdata),
    .xfer_done_evt(xfer_done_evt), .collision_evt(collision_evt),
    .serial_port_data_out(spd_out), .double_rate_select(drs));
  iosad_periph_model i_iosad_periph_model (.clk(clk), .per(per), .per_rdata(per_rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected refusal for a kind and address
  function automatic logic refused(input iosad_kind_e k, input logic [7:0] ad);
    if (k inside {OP_IN, OP_OUT}) return ad > 8'h3F;
    if (k inside {OP_DATA_LOAD, OP_DATA_STORE}) return ad < 8'h20;
    return ad > 8'h1F;
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request, held for one clock with no look at ready, then wait for done
  task automatic op(input iosad_kind_e k, input logic [7:0] ad, input logic [2:0] bs,
                    input logic [7:0] wd);
    @(posedge clk);
    req <= '{1'b1, k, ad, bs, wd};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    // a refused request answers at the taking edge, others hold ready low
    chk("busy", {7'h00, !req_ready}, {7'h00, !refused(k, ad)});
    for (int i = 0; i < 8 && rsp.done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    got = rsp;
    chk("done", {7'h00, got.done}, 8'h01);
    chk("ready back", {7'h00, req_ready}, 8'h01);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    xfer_done_evt = 1'b0;
    collision_evt = 1'b0;
    req = '0;
    d = 8'($urandom(32'hd919adc4));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    op(OP_DATA_LOAD, 8'h2D, 3'h0, 8'h00);
    chk("status reset", got.rdata, 8'h00);
    op(OP_IN, 8'h0E, 3'h0, 8'h00);
    chk("data reset", got.rdata, 8'h00);
    $display("test reset done");
    // every kind at its edge, then random kinds and addresses
    for (int i = 0; i < 32; i++) begin
      a = (i < 8) ? bnd[i] : 8'($urandom);
      b = (i < 8) ? 3'(i) : 3'($urandom_range(0, 7));
      op(iosad_kind_e'({1'b0, b}), a, 3'h0, 8'h00);
      d = {7'h00, refused(iosad_kind_e'({1'b0, b}), a)};
      chk("refusal", {7'h00, got.err}, d);
    end
    $display("test refusal done");
    // address mapping and bit operations on far registers
    for (int i = 0; i < 6; i++) begin
      a = 8'h60 + 8'($urandom_range(0, 159));
      d = 8'($urandom);
      op(OP_DATA_STORE, a, 3'h0, d);
      chk("ext store", i_iosad_periph_model.mem[a], d);
      a = 8'($urandom_range(16, 31));
      b = 3'($urandom);
      op(OP_OUT, a, 3'h0, d);
      chk("out map", i_iosad_periph_model.mem[a + 8'h20], d);
      op(OP_DATA_LOAD, a + 8'h20, 3'h0, 8'h00);
      chk("load map", got.rdata, d);
      op(OP_SET_IO_BIT, a, b, 8'h00);
      chk("set bit", i_iosad_periph_model.mem[a + 8'h20], d | (8'h01 << b));
      op(OP_CLEAR_IO_BIT, a, b, 8'h00);
      chk("clear bit", i_iosad_periph_model.mem[a + 8'h20], d & ~(8'h01 << b));
      op(OP_SKIP_BIT_SET, a, b, 8'h00);
      chk("skip set", {7'h00, got.skip}, 8'h00);
      op(OP_SKIP_BIT_CLR, a, b, 8'h00);
      chk("skip clear", {7'h00, got.skip}, 8'h01);
    end
    $display("test mapping done");
    // status flags: raise, keep on zero, clear on one
    op(OP_DATA_STORE, 8'h2D, 3'h0, 8'h00);
    @(posedge clk);
    xfer_done_evt <= 1'b1;
    collision_evt <= 1'b1;
    @(posedge clk);
    xfer_done_evt <= 1'b0;
    collision_evt <= 1'b0;
    op(OP_IN, 8'h0D, 3'h0, 8'h00);
    chk("flags up", got.rdata, 8'hC0);
    op(OP_OUT, 8'h0D, 3'h0, 8'h3E);
    op(OP_IN, 8'h0D, 3'h0, 8'h00);
    chk("zero keeps", got.rdata, 8'hC0);
    op(OP_OUT, 8'h0D, 3'h0, 8'h40);
    op(OP_IN, 8'h0D, 3'h0, 8'h00);
    chk("one clears", got.rdata, 8'h80);
    op(OP_SET_IO_BIT, 8'h0D, 3'h0, 8'h00);
    op(OP_DATA_LOAD, 8'h2D, 3'h0, 8'h00);
    chk("rmw clears", got.rdata, 8'h01);
    chk("rate select", {7'h00, drs}, 8'h01);
    op(OP_DATA_STORE, 8'h2E, 3'h0, 8'hA5);
    chk("data copy", spd_out, 8'hA5);
    // clock enable low: an event pulse is lost and every register holds
    @(posedge clk);
    ce <= 1'b0;
    xfer_done_evt <= 1'b1;
    @(posedge clk);
    xfer_done_evt <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    op(OP_IN, 8'h0D, 3'h0, 8'h00);
    chk("frozen flag", got.rdata, 8'h01);
    chk("frozen copy", spd_out, 8'hA5);
    $display("test status done");
    give_verdict();
  end
endmodule
`default_nettype wire
